// ---- design/acr_irq_bank.sv ----
// sticky interrupt status bits, read-to-clear, with mask gating
`timescale 1ns/1ps
`default_nettype none
module acr_irq_bank
   import acr_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [ACR_IRQ_N-1:0] event_in,
   input wire logic [ACR_IRQ_N-1:0] mask_in,
   input wire logic clear_in,
   output logic [ACR_IRQ_N-1:0] status_out,
   output logic irq_out
);

   logic [ACR_IRQ_N-1:0] status_q, status_d;
   logic irq_q, irq_d;

   // ==================================================================
   // per bit: an event wins over a clear in the same cycle
   genvar i;
   generate
      for (i = 0; i < ACR_IRQ_N; i++) begin : g_bit
         always_comb begin
            status_d[i] = event_in[i] | (status_q[i] & ~clear_in);
         end
      end
   endgenerate

   always_comb begin
      irq_d = |(status_d & mask_in);
   end

   // registers
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         status_q <= '0;
         irq_q <= 1'b0;
      end else begin
         status_q <= status_d;
         irq_q <= irq_d;
      end
   end

   assign status_out = status_q;
   assign irq_out = irq_q;

endmodule // acr_irq_bank
`default_nettype wire

// ---- design/acr_pkg.sv ----
// constants, field layouts and carrier types of the converter config and result registers
// How it works
// (RULE_01) input buffer field bits 9:8, reset 3; 00 off, 01 neg, 10 pos, 11 both
// (RULE_02) reference select bits 5:4, reset 0; 00 ext pins, 10 internal, 11 supply
// (RULE_03) host selecting the internal reference also sets reference enable elsewhere
// (RULE_04) bits 3..1 enable the three low-voltage channels, reset zero
// (RULE_05) bit 0 enables the high-voltage channel, read/write, reset zero
// (RULE_06) all channel enables zero means high-voltage channel runs anyway
// (RULE_07) result register at index 4, read-only, 24 bits, resets to zero
// (RULE_08) reading the result sets ready flag and data-out/ready pin high
// (RULE_09) result may be read again and again unchanged until replaced
// (RULE_10) after a read, nothing hints that another result is coming
// (RULE_11) a finished conversion waits while the result register is being read
// (RULE_12) append option adds the status byte, making the read 32 bits; with short word on, the code reads 24 bits with the top byte zero
// (RULE_13) short word option rounds results to 16 bits and narrows the register
// (RULE_14) short word takes effect from the next new result, not the held one
// (RULE_15) appended status is captured together with its own result word
// (RULE_16) a newly written result drives ready flag and pin low
package acr_pkg;

   // ==================================================================
   // register indices (byte address is four times the index)
   localparam logic [3:0] ACR_IDX_STATUS = 4'h0;
   localparam logic [3:0] ACR_IDX_IFACE = 4'h2;
   localparam logic [3:0] ACR_IDX_CONFIG = 4'h3;
   localparam logic [3:0] ACR_IDX_RESULT = 4'h4;
   localparam logic [3:0] ACR_IDX_IRQ_STAT = 4'h6;
   localparam logic [3:0] ACR_IDX_IRQ_MASK = 4'h7;
   localparam int ACR_ADDR_LSB = 2;
   localparam int ACR_ADDR_MSB = 5;

   // ==================================================================
   // configuration register layout
   localparam int ACR_CFG_W = 16;
   localparam int ACR_CFG_BUF_LO = 8;
   localparam int ACR_CFG_BUF_HI = 9;
   localparam int ACR_CFG_BIT6 = 6;
   localparam int ACR_CFG_REF_LO = 4;
   localparam int ACR_CFG_REF_HI = 5;
   localparam int ACR_CFG_CH_LO = 0;
   localparam int ACR_CFG_CH_HI = 3;
   localparam logic [15:0] ACR_CFG_WMASK = 16'h037F;
   localparam logic [15:0] ACR_CFG_RESET = 16'h0340;
   localparam logic [3:0] ACR_CH_NONE = 4'h0;
   localparam logic [3:0] ACR_CH_HV_ONLY = 4'h1;

   // reference select codes
   typedef enum logic [1:0] {
      ACR_REF_EXTERNAL = 2'b00,
      ACR_REF_RESERVED = 2'b01,
      ACR_REF_INTERNAL = 2'b10,
      ACR_REF_SUPPLY = 2'b11
   } acr_ref_sel_t;

   // ==================================================================
   // interface register layout
   localparam int ACR_IF_SHORT_WL = 0;
   localparam int ACR_IF_APPEND = 6;
   localparam logic [31:0] ACR_IF_WMASK = 32'h0000_0041;

   // ==================================================================
   // result and status layout
   localparam int ACR_RES_W = 24;
   localparam int ACR_SHORT_W = 16;
   localparam logic [23:0] ACR_RES_RESET = 24'h00_0000;
   localparam logic [15:0] ACR_SHORT_MAX = 16'hFFFF;
   localparam int ACR_ST_RDY = 7;
   localparam int ACR_ST_ERR_LO = 4;
   localparam int ACR_ST_CH_LO = 0;

   // interrupt status bits
   localparam int ACR_IRQ_N = 2;
   localparam int ACR_IRQ_NEW = 0;
   localparam int ACR_IRQ_HELD = 1;

   // ahb-lite transfer types
   localparam logic [1:0] ACR_HTRANS_NONSEQ = 2'b10;

   // conversion handed over by the modulator and filter
   typedef struct packed {
      logic [23:0] data;
      logic [2:0] err;
      logic [1:0] chan;
   } acr_conv_t;

   // result word as stored, with the status captured beside it
   typedef struct packed {
      logic [23:0] data;
      logic short_w;
      logic [2:0] err;
      logic [1:0] chan;
   } acr_result_t;

endpackage : acr_pkg

// ---- design/acr_result_store.sv ----
// result holding register with read hold-off and 16-bit rounding
`timescale 1ns/1ps
`default_nettype none
module acr_result_store
   import acr_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic conv_valid_in,
   input wire acr_conv_t conv_in,
   input wire logic hold_in,
   input wire logic short_wl_in,
   output acr_result_t word_out,
   output logic wrote_out,
   output logic held_out
);

   acr_result_t word_q, word_d;
   acr_conv_t pend_q, pend_d;
   logic pend_v_q, pend_v_d;
   logic wrote_q, wrote_d;
   logic held_q, held_d;

   // round 24 bits to 16 with saturation at full scale
   function automatic logic [23:0] round16(input logic [23:0] d);
      logic [16:0] sum;
      sum = {1'b0, d[23:8]} + {16'h0000, d[7]};
      if (sum[16]) begin
         round16 = {8'h00, ACR_SHORT_MAX};
      end else begin
         round16 = {8'h00, sum[15:0]};
      end
   endfunction

   // ==================================================================
   // next values: pending slot and stored word
   always_comb begin
      acr_conv_t src;
      src = pend_v_q ? pend_q : conv_in;
      word_d = word_q;
      pend_d = pend_q;
      pend_v_d = pend_v_q;
      wrote_d = 1'b0;
      held_d = 1'b0;
      if (hold_in) begin
         if (conv_valid_in) begin // RULE_11
            pend_d = conv_in;
            pend_v_d = 1'b1;
            held_d = 1'b1;
         end
      end else if (pend_v_q || conv_valid_in) begin
         if (pend_v_q && conv_valid_in) begin
            src = conv_in; // newest result replaces the stale pending one
         end
         word_d.data = short_wl_in ? round16(src.data) : src.data; // RULE_13 RULE_14
         word_d.short_w = short_wl_in;
         word_d.err = src.err; // RULE_15
         word_d.chan = src.chan;
         pend_v_d = 1'b0;
         wrote_d = 1'b1;
      end
   end

   // registers
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         word_q <= '0; // RULE_07
         pend_q <= '0;
         pend_v_q <= 1'b0;
         wrote_q <= 1'b0;
         held_q <= 1'b0;
      end else begin
         word_q <= word_d;
         pend_q <= pend_d;
         pend_v_q <= pend_v_d;
         wrote_q <= wrote_d;
         held_q <= held_d;
      end
   end

   assign word_out = word_q;
   assign wrote_out = wrote_q;
   assign held_out = held_q;

endmodule // acr_result_store
`default_nettype wire

// ---- design/acr_top.sv ----
// converter configuration and result registers behind an ahb-lite slave
`timescale 1ns/1ps
`default_nettype none
module acr_top
   import acr_pkg::*;
(
   input wire logic CORE_CLK_IN,
   input wire logic SYS_RST_IN,
   // ahb-lite slave
   input wire logic HSEL_IN,
   input wire logic [31:0] HADDR_IN,
   input wire logic [1:0] HTRANS_IN,
   input wire logic HWRITE_IN,
   input wire logic [2:0] HSIZE_IN,
   input wire logic [31:0] HWDATA_IN,
   input wire logic HREADY_IN,
   output logic [31:0] HRDATA_OUT,
   output logic HREADYOUT_OUT,
   output logic HRESP_OUT,
   // conversion from the modulator and filter
   input wire logic CONV_VALID_IN,
   input wire logic [23:0] CONV_DATA_IN,
   input wire logic [1:0] CONV_CHAN_IN,
   input wire logic [2:0] CONV_ERR_IN,
   // analog front end controls
   output logic AIN_BUF_POS_EN_OUT,
   output logic AIN_BUF_NEG_EN_OUT,
   output logic [1:0] REF_SEL_OUT,
   output logic [3:0] CHAN_ACTIVE_OUT,
   // ready indication and interrupt
   output logic DOUT_RDY_OUT,
   output logic IRQ_OUT
);

   // ==================================================================
   // declarations
   logic acc_ok;
   logic [3:0] acc_idx;
   logic in_range;
   logic rd_result;
   logic rd_irq;

   // bus phase tracking
   logic wr_pend_q, wr_pend_d;
   logic [3:0] wr_idx_q, wr_idx_d;
   logic rd_res_dp_q, rd_res_dp_d;

   // software registers and registered controls
   logic [15:0] cfg_q, cfg_d;
   logic [31:0] iface_q, iface_d;
   logic [ACR_IRQ_N-1:0] mask_q, mask_d;
   logic rdy_n_q, rdy_n_d;
   logic [31:0] rdata_q, rdata_d;
   logic buf_pos_q, buf_pos_d;
   logic buf_neg_q, buf_neg_d;
   logic [1:0] ref_q, ref_d;
   logic [3:0] chan_q, chan_d;

   // links to the result store and interrupt bank
   acr_conv_t conv;
   acr_result_t word;
   logic wrote;
   logic held;
   logic [ACR_IRQ_N-1:0] irq_status;
   logic irq;
   logic [7:0] stat_byte;
   logic [3:0] ch_en;

   // ==================================================================
   // address phase decode; hsize is not checked, only word transfers occur
   // address bits above the map make an access unmapped
   always_comb begin
      acc_ok = HSEL_IN & HREADY_IN & HTRANS_IN[1];
      acc_idx = HADDR_IN[ACR_ADDR_MSB:ACR_ADDR_LSB];
      in_range = (HADDR_IN[31:ACR_ADDR_MSB+1] == '0);
      rd_result = acc_ok & ~HWRITE_IN & in_range & (acc_idx == ACR_IDX_RESULT);
      rd_irq = acc_ok & ~HWRITE_IN & in_range & (acc_idx == ACR_IDX_IRQ_STAT);
   end

   // ==================================================================
   // result store and interrupt bank
   // pack the conversion inputs into one carrier
   assign conv = '{data: CONV_DATA_IN, err: CONV_ERR_IN, chan: CONV_CHAN_IN};

   // hold covers the address phase and the data phase of a result read
   // a conversion that lands meanwhile waits in one pending slot
   // so the word on the bus never changes under the reader
   acr_result_store u_store (
      .clk_in(CORE_CLK_IN),
      .rst_in(SYS_RST_IN),
      .conv_valid_in(CONV_VALID_IN),
      .conv_in(conv),
      .hold_in(rd_result | rd_res_dp_q), // RULE_11
      .short_wl_in(iface_q[ACR_IF_SHORT_WL]),
      .word_out(word),
      .wrote_out(wrote),
      .held_out(held)
   );

   // events: bit0 new result written, bit1 conversion held off by a read
   acr_irq_bank u_irq (
      .clk_in(CORE_CLK_IN),
      .rst_in(SYS_RST_IN),
      .event_in({held, wrote}),
      .mask_in(mask_q),
      .clear_in(rd_irq),
      .status_out(irq_status),
      .irq_out(irq)
   );

   // ==================================================================
   // bus tracking: write pending into data phase, result read in data phase
   // a write's index is kept for the data phase, when hwdata stands
   always_comb begin
      wr_pend_d = acc_ok & HWRITE_IN & in_range;
      wr_idx_d = acc_idx;
      rd_res_dp_d = rd_result;
   end

   // phase trackers
   always_ff @(posedge CORE_CLK_IN) begin
      if (SYS_RST_IN) begin
         wr_pend_q <= 1'b0;
         wr_idx_q <= 4'h0;
         rd_res_dp_q <= 1'b0;
      end else begin
         wr_pend_q <= wr_pend_d;
         wr_idx_q <= wr_idx_d;
         rd_res_dp_q <= rd_res_dp_d;
      end
   end

   // ==================================================================
   // software registers written in the data phase
   // unwritable bits are masked off, so they read back as zero
   always_comb begin
      cfg_d = cfg_q;
      iface_d = iface_q;
      mask_d = mask_q;
      if (wr_pend_q) begin
         case (wr_idx_q)
            ACR_IDX_CONFIG: begin
               cfg_d = HWDATA_IN[15:0] & ACR_CFG_WMASK; // RULE_01 RULE_02 RULE_04 RULE_05
            end
            ACR_IDX_IFACE: begin
               iface_d = HWDATA_IN & ACR_IF_WMASK; // RULE_14
            end
            ACR_IDX_IRQ_MASK: begin
               mask_d = HWDATA_IN[ACR_IRQ_N-1:0];
            end
            default: begin
               cfg_d = cfg_q; // result and status are read-only
            end
         endcase
      end
   end

   // software registers, back to power-on values on reset
   always_ff @(posedge CORE_CLK_IN) begin
      if (SYS_RST_IN) begin
         cfg_q <= ACR_CFG_RESET; // RULE_01 RULE_02 RULE_04 RULE_05
         iface_q <= 32'h0000_0000;
         mask_q <= '0;
      end else begin
         cfg_q <= cfg_d;
         iface_q <= iface_d;
         mask_q <= mask_d;
      end
   end

   // ==================================================================
   // ready flag: low on a new result, high once the result is read
   // a new result beats a read in the same cycle: clear wins over set
   // a read in that cycle returns the new result and leaves the flag low
   // the same flag appears as bit 7 of the status byte
   always_comb begin
      rdy_n_d = rdy_n_q;
      if (wrote) begin
         rdy_n_d = 1'b0; // RULE_16
      end else if (rd_result) begin
         rdy_n_d = 1'b1; // RULE_08 RULE_10
      end
   end

   // ready flag register
   always_ff @(posedge CORE_CLK_IN) begin
      if (SYS_RST_IN) begin
         rdy_n_q <= 1'b1;
      end else begin
         rdy_n_q <= rdy_n_d;
      end
   end

   // ==================================================================
   // read data, registered at the end of the address phase
   // the data phase then shows it with no wait state
   always_comb begin
      stat_byte = {rdy_n_q, word.err, 2'b00, word.chan}; // RULE_15
   end

   // register map read mux
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (acc_ok & ~HWRITE_IN & in_range) begin
         case (acc_idx)
            ACR_IDX_STATUS: begin
               rdata_d = {24'h00_0000, stat_byte};
            end
            ACR_IDX_IFACE: begin
               rdata_d = iface_q;
            end
            ACR_IDX_CONFIG: begin
               rdata_d = {16'h0000, cfg_q};
            end
            ACR_IDX_RESULT: begin
               // short words sit low, the status byte below them when appended
               if (iface_q[ACR_IF_APPEND]) begin // RULE_12
                  if (word.short_w) begin
                     rdata_d = {8'h00, word.data[15:0], stat_byte};
                  end else begin
                     rdata_d = {word.data, stat_byte};
                  end
               end else begin
                  rdata_d = {8'h00, word.data}; // RULE_07 RULE_09 RULE_13
               end
            end
            ACR_IDX_IRQ_STAT: begin
               rdata_d = {{(32-ACR_IRQ_N){1'b0}}, irq_status};
            end
            ACR_IDX_IRQ_MASK: begin
               rdata_d = {{(32-ACR_IRQ_N){1'b0}}, mask_q};
            end
            default: begin
               rdata_d = 32'h0000_0000; // unmapped reads as zero
            end
         endcase
      end
   end

   // read data register
   always_ff @(posedge CORE_CLK_IN) begin
      if (SYS_RST_IN) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // ==================================================================
   // front end controls decoded from the next configuration
   // so they change at the same edge as the configuration register
   always_comb begin
      ch_en = cfg_d[ACR_CFG_CH_HI:ACR_CFG_CH_LO];
      buf_pos_d = cfg_d[ACR_CFG_BUF_HI]; // RULE_01
      buf_neg_d = cfg_d[ACR_CFG_BUF_LO];
      ref_d = cfg_d[ACR_CFG_REF_HI:ACR_CFG_REF_LO]; // RULE_02
      chan_d = (ch_en == ACR_CH_NONE) ? ACR_CH_HV_ONLY : ch_en; // RULE_06
   end

   // control output registers
   always_ff @(posedge CORE_CLK_IN) begin
      if (SYS_RST_IN) begin
         buf_pos_q <= ACR_CFG_RESET[ACR_CFG_BUF_HI];
         buf_neg_q <= ACR_CFG_RESET[ACR_CFG_BUF_LO];
         ref_q <= ACR_CFG_RESET[ACR_CFG_REF_HI:ACR_CFG_REF_LO];
         chan_q <= ACR_CH_HV_ONLY;
      end else begin
         buf_pos_q <= buf_pos_d;
         buf_neg_q <= buf_neg_d;
         ref_q <= ref_d;
         chan_q <= chan_d;
      end
   end

   // ==================================================================
   // bus answer from a flip-flop: zero wait states
   always_ff @(posedge CORE_CLK_IN) begin
      if (SYS_RST_IN) begin
         HREADYOUT_OUT <= 1'b1;
      end else begin
         HREADYOUT_OUT <= 1'b1;
      end
   end

   // response is always okay, no access is ever refused with an error
   always_ff @(posedge CORE_CLK_IN) begin
      if (SYS_RST_IN) begin
         HRESP_OUT <= 1'b0;
      end else begin
         HRESP_OUT <= 1'b0;
      end
   end

   // output ports straight from their registers
   assign HRDATA_OUT = rdata_q;
   assign AIN_BUF_POS_EN_OUT = buf_pos_q;
   assign AIN_BUF_NEG_EN_OUT = buf_neg_q;
   assign REF_SEL_OUT = ref_q;
   assign CHAN_ACTIVE_OUT = chan_q;
   assign DOUT_RDY_OUT = rdy_n_q; // RULE_08 RULE_16
   assign IRQ_OUT = irq;

endmodule // acr_top
`default_nettype wire

// ---- testbench/acr_top_chk.sv ----
// concurrent checks on the converter config and result register ports
`timescale 1ns/1ps
`default_nettype none
module acr_chk
   import acr_pkg::*;
(
   input wire logic CORE_CLK_IN,
   input wire logic SYS_RST_IN,
   input wire logic HSEL_IN,
   input wire logic [31:0] HADDR_IN,
   input wire logic [1:0] HTRANS_IN,
   input wire logic HWRITE_IN,
   input wire logic [2:0] HSIZE_IN,
   input wire logic [31:0] HWDATA_IN,
   input wire logic HREADY_IN,
   input wire logic [31:0] HRDATA_OUT,
   input wire logic HREADYOUT_OUT,
   input wire logic HRESP_OUT,
   input wire logic CONV_VALID_IN,
   input wire logic [23:0] CONV_DATA_IN,
   input wire logic [1:0] CONV_CHAN_IN,
   input wire logic [2:0] CONV_ERR_IN,
   input wire logic AIN_BUF_POS_EN_OUT,
   input wire logic AIN_BUF_NEG_EN_OUT,
   input wire logic [1:0] REF_SEL_OUT,
   input wire logic [3:0] CHAN_ACTIVE_OUT,
   input wire logic DOUT_RDY_OUT,
   input wire logic IRQ_OUT
);
   logic rd_take;
   logic cfg_wr;

   // ==================================================================
   // result reads and config writes taken at an edge
   assign rd_take = HSEL_IN && HREADY_IN && HTRANS_IN[1] && !HWRITE_IN && HADDR_IN == 32'h0000_0010;
   assign cfg_wr = HSEL_IN && HREADY_IN && HTRANS_IN[1] && HWRITE_IN && HADDR_IN == 32'h0000_000C;

   default clocking cb @(posedge CORE_CLK_IN);
   endclocking
   default disable iff (SYS_RST_IN);

   // ==================================================================
   // assertions
   a_reset_vals: assert property ($fell(SYS_RST_IN) |-> AIN_BUF_POS_EN_OUT && AIN_BUF_NEG_EN_OUT
      && REF_SEL_OUT == 2'b00 && CHAN_ACTIVE_OUT == 4'h1 && DOUT_RDY_OUT) else $error("reset values wrong");
   a_chan_never_zero: assert property (CHAN_ACTIVE_OUT != 4'h0) else $error("no channel active");
   a_chan_follow: assert property (cfg_wr ##1 1'b1 |=> CHAN_ACTIVE_OUT ==
      (($past(HWDATA_IN[3:0]) == 4'h0) ? 4'h1 : $past(HWDATA_IN[3:0]))) else $error("channel enables wrong");
   a_buf_follow: assert property (cfg_wr ##1 1'b1 |=>
      {AIN_BUF_POS_EN_OUT, AIN_BUF_NEG_EN_OUT} == $past(HWDATA_IN[9:8])) else $error("buffer enables wrong");
   a_ref_follow: assert property (cfg_wr ##1 1'b1 |=> REF_SEL_OUT == $past(HWDATA_IN[5:4]))
      else $error("reference select wrong");
   a_ready_on_read: assert property (rd_take && !$past(rd_take) && !$past(rd_take, 2) && !CONV_VALID_IN
      && !$past(CONV_VALID_IN) && !$past(CONV_VALID_IN, 2) |=> DOUT_RDY_OUT) else $error("read left ready low");
   a_new_result_low: assert property (CONV_VALID_IN && !rd_take && !$past(rd_take) ##1 !rd_take
      |=> !DOUT_RDY_OUT) else $error("new result not flagged");
   a_read_holdoff: assert property (rd_take && CONV_VALID_IN && !$past(rd_take)
      && !$past(CONV_VALID_IN) |=> DOUT_RDY_OUT) else $error("result written during read");
   a_result_stable: assert property (rd_take && !$past(CONV_VALID_IN) && !$past(CONV_VALID_IN, 2)
      ##0 (!CONV_VALID_IN [*4]) ##0 rd_take |=> HRDATA_OUT[31:8] == $past(HRDATA_OUT[31:8], 3))
      else $error("result changed between reads");
   a_bus_okay: assert property (HREADYOUT_OUT && !HRESP_OUT) else $error("bus answer not ready and okay");

   // main scenarios seen
   c_result_read: cover property (rd_take);
   c_held_conv: cover property (rd_take && CONV_VALID_IN);
   c_irq_raised: cover property ($rose(IRQ_OUT));
endmodule // acr_chk

bind acr_top acr_chk i_chk (.*);
`default_nettype wire

// ---- testbench/adc_config_and_result_regs_test.sv ----
// self-checking bench for the converter config and result registers
`timescale 1ns/1ps
`default_nettype none
module adc_config_and_result_regs_test
   import acr_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0, hwrite = 1'b0, cv = 1'b0;
   logic [1:0] htrans = 2'b00, cch = 2'b00;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rd;
   logic [2:0] cerr = 3'b000;
   logic [23:0] cdata = 24'h00_0000;
   logic [31:0] hrdata;
   logic hreadyout, hresp, bpos, bneg, rdy_n, irq;
   logic [1:0] rsel;
   logic [3:0] chan;
   int error_cnt = 0;
   int compares = 0;

   acr_top i_dut (
      .CORE_CLK_IN(clk), .SYS_RST_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
      .HWRITE_IN(hwrite), .HSIZE_IN(3'b010), .HWDATA_IN(hwdata), .HREADY_IN(hreadyout),
      .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hreadyout), .HRESP_OUT(hresp), .CONV_VALID_IN(cv),
      .CONV_DATA_IN(cdata), .CONV_CHAN_IN(cch), .CONV_ERR_IN(cerr), .AIN_BUF_POS_EN_OUT(bpos),
      .AIN_BUF_NEG_EN_OUT(bneg), .REF_SEL_OUT(rsel), .CHAN_ACTIVE_OUT(chan), .DOUT_RDY_OUT(rdy_n),
      .IRQ_OUT(irq)
   );

   // ==================================================================
   // clock and watchdog
   initial begin
      forever #5 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      end_of_test();
   end

   // ==================================================================
   // shared tasks and expectation functions
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one single transfer, read data taken at the data phase edge
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= ACR_HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic rdx(input logic [31:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask

   // one-cycle conversion pulse
   task automatic conv(input logic [23:0] d, input logic [1:0] c, input logic [2:0] e);
      @(posedge clk);
      cv <= 1'b1;
      cdata <= d;
      cch <= c;
      cerr <= e;
      @(posedge clk);
      cv <= 1'b0;
   endtask

   function automatic logic [15:0] rnd16(input logic [23:0] d);
      logic [16:0] s;
      s = {1'b0, d[23:8]} + {16'h0000, d[7]};
      return s[16] ? 16'hffff : s[15:0];
   endfunction

   function automatic logic [7:0] st8(input logic r, input logic [2:0] e, input logic [1:0] c);
      return {r, e, 2'b00, c};
   endfunction

   task automatic end_of_test;
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ==================================================================
   // main sequence
   initial begin
      logic [31:0] d;
      logic [23:0] cd, old;
      logic [2:0] ce;
      d = $urandom(32'hd5e0_32e5);
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      chk(32'({hreadyout, hresp, bpos, bneg, rsel, chan, rdy_n, irq}), 32'h0000_0B06);
      rdx(32'h0000_000C, 32'h0000_0340);
      rdx(32'h0000_0010, 32'h0000_0000);
      $display("test reset done");
      // every buffer and reference code, channel bits random or all zero
      for (int i = 0; i < 16; i++) begin
         d = $urandom;
         d[9:8] = i[1:0];
         d[5:4] = i[3:2];
         d[3:0] = (i < 3) ? 4'h0 : d[3:0];
         xfer(1'b1, 32'h0000_000C, d);
         #1;
         chk(32'({bpos, bneg}), 32'(d[9:8]));
         chk(32'(rsel), 32'(d[5:4]));
         chk(32'(chan), (d[3:0] == 4'h0) ? 32'h0000_0001 : 32'(d[3:0]));
         rdx(32'h0000_000C, d & 32'h0000_037F);
      end
      xfer(1'b1, 32'h0000_0010, 32'hffff_ffff);
      rdx(32'h0000_0010, 32'h0000_0000);
      rdx(32'h0000_0040, 32'h0000_0000);
      $display("test config done");
      // full results, ready and interrupt per conversion
      xfer(1'b1, 32'h0000_001C, 32'h0000_0003);
      for (int k = 0; k < 4; k++) begin
         cd = (k == 0) ? 24'hff_ffff : 24'($urandom);
         ce = 3'($urandom);
         conv(cd, 2'(k), ce);
         repeat (2) @(posedge clk);
         #1;
         chk(32'({rdy_n, irq}), 32'h0000_0001);
         rdx(32'h0000_0010, {8'h00, cd});
         #1;
         chk(32'(rdy_n), 32'h0000_0001);
         rdx(32'h0000_0010, {8'h00, cd});
         rdx(32'h0000_0000, {24'h00_0000, st8(1'b1, ce, 2'(k))});
         rdx(32'h0000_0018, 32'h0000_0001);
         #1;
         chk(32'(irq), 32'h0000_0000);
      end
      $display("test conversion done");
      // short word takes effect from the next result only
      xfer(1'b1, 32'h0000_0008, 32'h0000_0001);
      rdx(32'h0000_0010, {8'h00, cd});
      for (int k = 0; k < 3; k++) begin
         cd = (k == 0) ? 24'hff_ff80 : ((k == 1) ? 24'h12_347f : 24'($urandom));
         conv(cd, 2'(k), 3'h0);
         repeat (2) @(posedge clk);
         rdx(32'h0000_0010, {16'h0000, rnd16(cd)});
      end
      // appended status in both word lengths, every channel
      for (int j = 0; j < 4; j++) begin
         d = j[0] ? 32'h0000_0041 : 32'h0000_0040;
         xfer(1'b1, 32'h0000_0008, d);
         rdx(32'h0000_0008, d);
         cd = 24'($urandom);
         ce = 3'($urandom);
         conv(cd, 2'(j), ce);
         repeat (2) @(posedge clk);
         rdx(32'h0000_0010, j[0] ? {8'h00, rnd16(cd), st8(1'b0, ce, 2'(j))}
            : {cd, st8(1'b0, ce, 2'(j))});
      end
      $display("test word format done");
      // conversion finishing during a result read waits
      xfer(1'b1, 32'h0000_0008, 32'h0000_0000);
      old = 24'($urandom);
      conv(old, 2'h0, 3'h0);
      repeat (2) @(posedge clk);
      xfer(1'b0, 32'h0000_0018, 32'h0000_0000);
      cd = 24'($urandom);
      fork
         rdx(32'h0000_0010, {8'h00, old});
         conv(cd, 2'h1, 3'h0);
      join
      repeat (4) @(posedge clk);
      #1;
      chk(32'(rdy_n), 32'h0000_0000);
      rdx(32'h0000_0010, {8'h00, cd});
      rdx(32'h0000_0018, 32'h0000_0003);
      // masked events leave the interrupt low
      xfer(1'b1, 32'h0000_001C, 32'h0000_0000);
      rdx(32'h0000_001C, 32'h0000_0000);
      conv(cd, 2'h2, 3'h0);
      repeat (3) @(posedge clk);
      #1;
      chk(32'(irq), 32'h0000_0000);
      rdx(32'h0000_0018, 32'h0000_0001);
      $display("test hold-off and mask done");
      end_of_test();
   end
endmodule // adc_config_and_result_regs_test
`default_nettype wire
